// ===== xport_regs.svh
// constants for the expansion port host controller
`ifndef XPORT_REGS_SVH
`define XPORT_REGS_SVH
`define XP_ADDR_W 10
`define XP_DATA_W 16
`define XP_CLK_NS 25
`define XP_BERR_NS 125000
`define XP_BERR_CYC ((`XP_BERR_NS + `XP_CLK_NS - 1) / `XP_CLK_NS)
`define XP_RST_CYC 520
`define XP_FAST_LAST 16'h0004
`define XP_FAST_HIGH 16'h0003
`define XP_SLOW_PHASE 32'h1797CC3A
`define XP_SOFT_LAST 3'h7
`define XP_SLOW_HIGH 32'h9999999A
`define XP_IPL_SERIAL 3'h3
`define XP_IPL_TIMER 3'h4
`define XP_IPL_NONE 3'h0
`endif

// ===== xport_pkg.sv
// types for the expansion port host controller
package xport_pkg;
   typedef enum logic [2:0] {ST_IDLE, ST_SETUP, ST_WAIT, ST_HOLD, ST_GAP} cycle_state_e;
   typedef enum logic [1:0] {WID_NONE, WID_BYTE, WID_HALF, WID_ERR} port_width_e;
endpackage : xport_pkg

// ===== sync3.sv
// three-flop synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module sync3 #(parameter int W = 1, parameter logic [W-1:0] INIT = '1) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // asynchronous in, filtered out
   input wire logic [W-1:0] async_in,
   output var logic [W-1:0] sync_out
);
   logic [W-1:0] s1_reg;
   logic [W-1:0] s2_reg;
   logic [W-1:0] s3_reg;
   genvar i;
   // per bit: chain and accept once stage two and three agree
   generate
      for (i = 0; i < W; i++) begin : g_bit
         always_ff @(posedge clock or negedge resetn) begin
            if (!resetn) begin
               s1_reg[i] <= INIT[i];
               s2_reg[i] <= INIT[i];
               s3_reg[i] <= INIT[i];
               sync_out[i] <= INIT[i];
            end else begin
               s1_reg[i] <= async_in[i];
               s2_reg[i] <= s1_reg[i];
               s3_reg[i] <= s2_reg[i];
               if (s2_reg[i] == s3_reg[i]) begin
                  sync_out[i] <= s3_reg[i];
               end
            end
         end
      end
   endgenerate
endmodule : sync3
`default_nettype wire

// ===== xport_host.sv
// host end of the asynchronous i/o expansion port
`timescale 1ns/1ps
`default_nettype none
`include "xport_regs.svh"
module xport_host
   import xport_pkg::*;
#(
   parameter int BERR_CYC = `XP_BERR_CYC
) (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // processor side request
   input wire logic req_valid,
   input wire logic req_read,
   input wire logic [`XP_ADDR_W-1:0] req_addr,
   input wire logic [`XP_DATA_W-1:0] req_wdata,
   input wire logic soft_reset,
   output logic req_ready,
   output logic done,
   output logic bus_error,
   output logic [1:0] done_width,
   output logic [`XP_DATA_W-1:0] rdata,
   output logic system_reset_seen,
   output logic [2:0] irq_level,
   // port address and control
   output logic [`XP_ADDR_W-1:0] port_addr,
   output logic port_rw,
   output logic port_sel_n,
   input wire logic byte_ack_n,
   input wire logic halfword_ack_n,
   // data 31..16 as three signals
   input wire logic [`XP_DATA_W-1:0] data_in,
   output logic [`XP_DATA_W-1:0] data_out,
   output logic data_oe,
   // shared reset line, open drain
   input wire logic rst_line_in,
   output logic rst_line_out,
   output logic rst_line_oe,
   // interrupt inputs
   input wire logic serial_irq_n,
   input wire logic timer_irq_n,
   // auxiliary clocks
   output logic aux_clock_fast,
   output logic aux_clock_slow
);
   cycle_state_e state_reg;
   logic [1:0] ack_n_s;
   logic [1:0] irq_n_s;
   logic rst_in_s;
   logic [31:0] to_reg;
   logic [9:0] rst_cnt_reg;
   logic [2:0] soft_cnt_reg;
   logic [15:0] fast_cnt_reg;
   logic fast_rise_reg;
   logic fast_fall_reg;
   logic [31:0] slow_acc_reg;
   logic acked;

   // synchronise acknowledges, interrupts and reset line
   // synchronised inputs
   sync3 #(.W(5), .INIT(5'h1F)) u_sync (
      .clock(clock),
      .resetn(resetn),
      .async_in({byte_ack_n, halfword_ack_n, serial_irq_n, timer_irq_n, rst_line_in}),
      .sync_out({ack_n_s, irq_n_s, rst_in_s})
   );

   assign acked = !(ack_n_s[1] && ack_n_s[0]);
   assign req_ready = (state_reg == ST_IDLE) && !rst_line_oe;

   // cycle sequencer
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         state_reg <= ST_IDLE;
      end else begin
         case (state_reg)
            ST_IDLE: if (req_valid && req_ready) state_reg <= ST_SETUP;
            ST_SETUP: state_reg <= ST_WAIT;
            ST_WAIT: if (acked || to_reg >= 32'(BERR_CYC)) state_reg <= ST_HOLD;
            ST_HOLD: state_reg <= ST_GAP;
            ST_GAP: if (!acked) state_reg <= ST_IDLE;
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // timeout counter from select assertion
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         to_reg <= 32'h00000000;
      end else if (state_reg == ST_WAIT) begin
         to_reg <= to_reg + 32'h00000001;
      end else begin
         to_reg <= 32'h00000000;
      end
   end

   // address, direction, write data and select
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         port_addr <= '0;
         port_rw <= 1'b1;
         data_out <= '0;
         data_oe <= 1'b0;
         port_sel_n <= 1'b1;
      end else begin
         if (state_reg == ST_IDLE && req_valid && req_ready) begin
            // one aligned unit, wider moves split upstream
            port_addr <= req_addr;
            port_rw <= req_read;
            data_out <= req_wdata;
            data_oe <= !req_read;
         end else if (state_reg == ST_GAP && !acked) begin
            data_oe <= 1'b0;
         end
         port_sel_n <= !(state_reg == ST_SETUP || (state_reg == ST_WAIT && !acked && to_reg < 32'(BERR_CYC)));
      end
   end

   // completion, width and read data capture
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         done <= 1'b0;
         bus_error <= 1'b0;
         done_width <= WID_NONE;
         rdata <= '0;
      end else begin
         done <= 1'b0;
         bus_error <= 1'b0;
         if (state_reg == ST_WAIT && acked) begin
            done <= 1'b1;
            done_width <= !ack_n_s[0] ? WID_HALF : WID_BYTE;
            if (port_rw) rdata <= !ack_n_s[0] ? data_in : {8'h00, data_in[15:8]};
         end else if (state_reg == ST_WAIT && to_reg >= 32'(BERR_CYC)) begin
            bus_error <= 1'b1;
            done_width <= WID_ERR;
         end
      end
   end

   // drive reset line on soft reset
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         soft_cnt_reg <= 3'h0;
         rst_line_oe <= 1'b1;
      end else begin
         if (soft_reset) soft_cnt_reg <= `XP_SOFT_LAST;
         else if (soft_cnt_reg != 3'h0) soft_cnt_reg <= soft_cnt_reg - 3'h1;
         rst_line_oe <= soft_reset || (soft_cnt_reg != 3'h0);
      end
   end
   assign rst_line_out = 1'b0;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         rst_cnt_reg <= 10'h000;
         system_reset_seen <= 1'b0;
      end else begin
         system_reset_seen <= 1'b0;
         if (rst_in_s || rst_line_oe) begin
            rst_cnt_reg <= 10'h000;
         end else if (rst_cnt_reg < 10'(`XP_RST_CYC)) begin
            rst_cnt_reg <= rst_cnt_reg + 10'h001;
            system_reset_seen <= (rst_cnt_reg == 10'(`XP_RST_CYC - 1));
         end
      end
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_level <= `XP_IPL_NONE;
      end else if (!irq_n_s[0]) begin
         irq_level <= `XP_IPL_TIMER;
      end else if (!irq_n_s[1]) begin
         irq_level <= `XP_IPL_SERIAL;
      end else begin
         irq_level <= `XP_IPL_NONE;
      end
   end

   // fast clock divider, five clocks a period, high for three
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         fast_cnt_reg <= 16'h0000;
         fast_rise_reg <= 1'b0;
      end else begin
         if (fast_cnt_reg == `XP_FAST_LAST) begin
            fast_cnt_reg <= 16'h0000;
         end else begin
            fast_cnt_reg <= fast_cnt_reg + 16'h0001;
         end
         fast_rise_reg <= (fast_cnt_reg < `XP_FAST_HIGH);
      end
   end
   // same phase half a clock later; five clocks cannot split evenly on one edge
   always_ff @(negedge clock or negedge resetn) begin
      if (!resetn) begin
         fast_fall_reg <= 1'b0;
      end else begin
         fast_fall_reg <= fast_rise_reg;
      end
   end
   // free-running output, 2.5 clocks high of 5, no glitch as the flops never move together
   assign aux_clock_fast = fast_rise_reg && fast_fall_reg;

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         slow_acc_reg <= 32'h00000000;
         aux_clock_slow <= 1'b0;
      end else begin
         slow_acc_reg <= slow_acc_reg + `XP_SLOW_PHASE;
         aux_clock_slow <= (slow_acc_reg < `XP_SLOW_HIGH);
      end
   end

   AST_ACK_BEFORE_DONE: assert property (@(posedge clock) disable iff (!resetn)
      done |-> $past(acked)) else $error("done without acknowledge");
   AST_RW_STABLE: assert property (@(posedge clock) disable iff (!resetn)
      (!port_sel_n && !$past(port_sel_n)) |-> $stable(port_rw)) else $error("rw moved");
   AST_BERR: assert property (@(posedge clock) disable iff (!resetn)
      bus_error |-> !$past(acked)) else $error("bus error with ack");
   AST_WIDTH: assert property (@(posedge clock) disable iff (!resetn)
      done |-> (done_width == WID_BYTE || done_width == WID_HALF)) else $error("bad width");
   AST_RST_LOW: assert property (@(posedge clock) disable iff (!resetn)
      soft_reset |=> rst_line_oe [*7]) else $error("reset not held");
   AST_IRQ3: assert property (@(posedge clock) disable iff (!resetn)
      (irq_n_s[0] && !irq_n_s[1]) |=> irq_level == `XP_IPL_SERIAL) else $error("no level 3");
   AST_IRQ4: assert property (@(posedge clock) disable iff (!resetn)
      !irq_n_s[0] |=> irq_level == `XP_IPL_TIMER) else $error("no level 4");
   AST_DOE: assert property (@(posedge clock) disable iff (!resetn)
      data_oe |-> !port_rw) else $error("drive during read");
   // handshake steps: acknowledge seen under select, then select released with done
   sequence seq_ack_under_sel;
      !port_sel_n && acked;
   endsequence
   sequence seq_cycle_closed;
      port_sel_n && done;
   endsequence
   AST_SEL_RELEASE: assert property (@(posedge clock) disable iff (!resetn)
      seq_ack_under_sel |=> seq_cycle_closed) else $error("select held after acknowledge");
   AST_SEL_TIMEOUT: assert property (@(posedge clock) disable iff (!resetn)
      (state_reg == ST_WAIT && !acked && to_reg >= 32'(BERR_CYC)) |=> (port_sel_n && bus_error))
      else $error("no abort at timeout");
endmodule : xport_host
`default_nettype wire

// ===== xport_periph.sv
// peripheral board model on the far side of the port
`timescale 1ns/1ps
`default_nettype none
module xport_periph (
   // clock and reset
   input wire logic clock,
   input wire logic resetn,
   // port from the host
   input wire logic port_sel_n,
   input wire logic port_rw,
   input wire logic [15:0] data_out,
   // behaviour chosen by the bench
   input wire logic wide,
   input wire logic mute,
   input wire logic [3:0] delay,
   input wire logic [15:0] rd_value,
   // answers to the host
   output logic byte_ack_n,
   output logic halfword_ack_n,
   output var logic [15:0] data_in,
   output var logic [15:0] wr_seen
);
   logic [3:0] cnt_reg;
   logic ack_reg;
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         cnt_reg <= 4'h0;
         ack_reg <= 1'h0;
         wr_seen <= 16'h0000;
      end else if (port_sel_n) begin
         cnt_reg <= 4'h0;
         ack_reg <= 1'h0;
      end else if (!mute && cnt_reg == delay) begin
         ack_reg <= 1'h1;
         if (!port_rw) wr_seen <= data_out;
      end else if (!ack_reg) begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
   assign byte_ack_n = !(ack_reg && !wide);
   assign halfword_ack_n = !(ack_reg && wide);
   // drive only on selected reads, else moving
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) data_in <= 16'h0000;
      else if (!port_sel_n && port_rw && !mute) data_in <= wide ? rd_value : {rd_value[15:8], ~data_in[7:0]};
      else data_in <= ~data_in;
   end
endmodule : xport_periph
`default_nettype wire

// ===== tb.sv
// self-checking bench for the expansion port host
`timescale 1ns/1ps
`default_nettype none
module tb
   import xport_pkg::*;
;
   localparam int BERR = 50;
   logic clock = 1'h0, resetn = 1'h0, req_valid = 1'h0, req_read = 1'h0, soft_reset = 1'h0;
   logic wide = 1'h0, mute = 1'h0, ext_rst = 1'h0, serial_irq_n = 1'h1, timer_irq_n = 1'h1, exp_rw = 1'h1;
   logic [9:0] req_addr = 10'h000, exp_addr = 10'h000;
   logic [15:0] req_wdata = 16'h0000, rd_value = 16'h0000, exp_wd = 16'h0000;
   logic [3:0] delay = 4'h0;
   logic req_ready, done, bus_error, system_reset_seen, port_rw, port_sel_n, byte_ack_n, halfword_ack_n;
   logic data_oe, rst_line_in, rst_line_out, rst_line_oe, aux_clock_fast, aux_clock_slow;
   logic [1:0] done_width;
   logic [2:0] irq_level;
   logic [9:0] port_addr;
   logic [15:0] rdata, data_in, data_out, wr_seen;
   int failures = 0, n_checks = 0, cyc = 0;
   assign rst_line_in = !((rst_line_oe && !rst_line_out) || ext_rst);
   xport_host #(.BERR_CYC(BERR)) xport_host_i (.clock, .resetn, .req_valid, .req_read, .req_addr, .req_wdata,
      .soft_reset, .req_ready, .done, .bus_error, .done_width, .rdata, .system_reset_seen, .irq_level,
      .port_addr, .port_rw, .port_sel_n, .byte_ack_n, .halfword_ack_n, .data_in, .data_out, .data_oe,
      .rst_line_in, .rst_line_out, .rst_line_oe, .serial_irq_n, .timer_irq_n, .aux_clock_fast, .aux_clock_slow);
   xport_periph xport_periph_i (.clock, .resetn, .port_sel_n, .port_rw, .data_out, .wide, .mute, .delay,
      .rd_value, .byte_ack_n, .halfword_ack_n, .data_in, .wr_seen);
   // 40 MHz clock
   initial forever #12.5 clock = ~clock;
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk
   task automatic report_and_stop;
      if (failures == 0 && n_checks > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : report_and_stop
   task automatic xfer(input logic rd, w, e, input logic [9:0] a, input logic [15:0] v, input logic [3:0] d);
      int n = 0;
      while (req_ready !== 1'h1) @(negedge clock);
      @(posedge clock);
      {wide, mute, delay, rd_value} <= {w, e, d, v};
      {exp_rw, exp_addr, exp_wd} <= {rd, a, v};
      {req_valid, req_read, req_addr, req_wdata} <= {1'h1, rd, a, v};
      @(posedge clock);
      req_valid <= 1'h0;
      while (done !== 1'h1 && bus_error !== 1'h1 && n < 200) begin
         @(negedge clock);
         n++;
      end
      chk("end", {14'h0, e, !e}, {14'h0, bus_error, done});
      if (e) chk("berr_time", 16'h1, {15'h0, n >= BERR - 2 && n <= BERR + 6});
      else chk("width", {14'h0, w ? WID_HALF : WID_BYTE}, {14'h0, done_width});
      if (!e && rd) chk("rdata", w ? v : {8'h00, v[15:8]}, rdata);
      if (!e && !rd) chk("wr_seen", w ? v : {v[15:8], 8'h00}, w ? wr_seen : {wr_seen[15:8], 8'h00});
   endtask : xfer
   // interrupt lines pulled low or released
   task automatic irq(input logic s, t, input logic [2:0] e);
      @(posedge clock);
      {serial_irq_n, timer_irq_n} <= {s, t};
      // settle past the three-flop filter and the level register
      repeat (8) @(negedge clock);
      chk("irq_level", {13'h0, e}, {13'h0, irq_level});
   endtask : irq
   task automatic soft_rst;
      int n = 0;
      @(posedge clock);
      soft_reset <= 1'h1;
      @(posedge clock);
      soft_reset <= 1'h0;
      repeat (20) begin
         @(negedge clock);
         if (rst_line_oe === 1'h1 && rst_line_out === 1'h0) n++;
      end
      chk("soft_rst_len", 16'h0008, n[15:0]);
   endtask : soft_rst
   task automatic ext_hold(input int len, input logic e);
      int n = 0;
      @(posedge clock);
      ext_rst <= 1'h1;
      repeat (len) begin
         @(negedge clock);
         if (system_reset_seen === 1'h1) n++;
      end
      @(posedge clock);
      ext_rst <= 1'h0;
      repeat (8) begin
         @(negedge clock);
         if (system_reset_seen === 1'h1) n++;
      end
      chk("sys_rst", {15'h0, e}, n[15:0]);
   endtask : ext_hold
   task automatic aux_chk;
      int hf = 0, hs = 0, ef = 0, es = 0;
      logic pf = 1'h0, ps = 1'h0;
      repeat (10000) begin
         #1;
         hf += aux_clock_fast;
         hs += aux_clock_slow;
         ef += aux_clock_fast && !pf;
         es += aux_clock_slow && !ps;
         pf = aux_clock_fast;
         ps = aux_clock_slow;
      end
      chk("fast_edges", 16'h1, {15'h0, ef >= 79 && ef <= 81});
      chk("fast_duty", 16'h1, {15'h0, hf >= 4800 && hf <= 5200});
      chk("slow_edges", 16'h1, {15'h0, es >= 36 && es <= 38});
      chk("slow_duty", 16'h1, {15'h0, hs >= 3500 && hs <= 6500 && (hs <= 4500 || hs >= 5500)});
   endtask : aux_chk
   // port lines steady while selected
   always @(negedge clock) begin
      if (resetn && !port_sel_n) begin
         chk("rw_addr", {5'h00, exp_rw, exp_addr}, {5'h00, port_rw, port_addr});
         chk("data_oe", {15'h0, !exp_rw}, {15'h0, data_oe});
         if (!exp_rw) chk("data_out", exp_wd, data_out);
      end
   end
   // cycle ceiling against hangs
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         failures++;
         report_and_stop();
      end
   end
   // main sequence
   initial begin
      repeat (12) @(posedge clock);
      chk("rst_drive", 16'h1, {15'h0, rst_line_oe === 1'h1 && rst_line_out === 1'h0});
      resetn <= 1'h1;
      xfer(1'h1, 1'h0, 1'h0, 10'h3FF, 16'hA55A, 4'h0);
      xfer(1'h1, 1'h1, 1'h0, 10'h000, 16'h5AC3, 4'h9);
      xfer(1'h0, 1'h0, 1'h0, 10'h155, 16'hC33C, 4'h2);
      xfer(1'h0, 1'h1, 1'h0, 10'h2AA, 16'h0FF0, 4'h0);
      xfer(1'h1, 1'h1, 1'h1, 10'h100, 16'h1234, 4'h0);
      xfer(1'h0, 1'h1, 1'h0, 10'h102, 16'hBEEF, 4'h1);
      irq(1'h0, 1'h1, 3'h3);
      irq(1'h1, 1'h0, 3'h4);
      irq(1'h0, 1'h0, 3'h4);
      irq(1'h1, 1'h1, 3'h0);
      soft_rst();
      ext_hold(505, 1'h0);
      ext_hold(540, 1'h1);
      xfer(1'h1, 1'h0, 1'h0, 10'h001, 16'h7E81, 4'h3);
      aux_chk();
      report_and_stop();
   end
endmodule : tb
`default_nettype wire
